// [rtl/rgs_pkg.sv]
package rgs_pkg;
    // two-wire target address and command codes
    localparam logic [6:0] TARGET_ADDR = 7'h10;
    localparam logic [7:0] CMD_CONFIG = 8'h00;
    localparam logic [7:0] CMD_RSVD_FIRST = 8'h01;
    localparam logic [7:0] CMD_RSVD_LAST = 8'h07;
    localparam logic [7:0] CMD_RED = 8'h08;
    localparam logic [7:0] CMD_GREEN = 8'h09;
    localparam logic [7:0] CMD_BLUE = 8'h0a;
    localparam logic [7:0] CMD_WHITE = 8'h0b;
    // configuration word fields
    localparam int CFG_POWER_DOWN_BIT = 0;
    localparam int CFG_FORCE_BIT = 1;
    localparam int CFG_KICK_BIT = 2;
    localparam int CFG_TIME_LSB = 4;
    localparam int CFG_TIME_MSB = 6;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] CFG_WRITE_MASK = 16'h0077;
    localparam logic [2:0] TIME_CODE_MAX = 3'h5;
    // timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int unsigned TIME_BASE_MS = 40;
    localparam int unsigned TIME_BASE_CYCLES = TIME_BASE_MS * (CLK_HZ / 1000);
    localparam int unsigned BUS_MIN_KHZ = 100;
    localparam int unsigned BUS_MAX_KHZ = 400;
    localparam int unsigned SCL_HIGH_MIN_NS = 600;
    localparam int unsigned SCL_HIGH_MIN_CYCLES = SCL_HIGH_MIN_NS / CLK_PERIOD_NS;
    localparam int unsigned NUM_CHANNELS = 4;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WRITE,
        ST_READ,
        ST_SKIP
    } rgs_state_t;
endpackage : rgs_pkg

// [rtl/rgs_pin_sync.sv]
`timescale 1ns/1ps
module rgs_pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinSync
);
    import rgs_pkg::*;
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    if (WIDTH < 1) begin : g_bad_width
        $error("rgs_pin_sync: WIDTH must be at least 1");
    end

    // two flops; idle bus lines are high, so reset to ones
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stage1 <= {WIDTH{1'b1}};
            stage2 <= {WIDTH{1'b1}};
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
        end
    end

    assign pinSync = stage2;
endmodule : rgs_pin_sync

// [rtl/rgs_meas_timer.sv]
`timescale 1ns/1ps
module rgs_meas_timer #(
    parameter int unsigned BASE_CYCLES = rgs_pkg::TIME_BASE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic run,
    input wire logic [2:0] timeSel,
    output logic done
);
    import rgs_pkg::*;
    logic [31:0] count;
    logic [31:0] target;
    logic [2:0] timeClamp;
    logic [2:0] timeHeld;
    logic codeChange;

    // 32 bits must hold the base count shifted by the longest code
    if (BASE_CYCLES < 1 || BASE_CYCLES > 32'h03ff_ffff) begin : g_bad_base
        $error("rgs_meas_timer: BASE_CYCLES out of range");
    end

    // undefined codes above the longest setting run at the longest time
    assign timeClamp = (timeSel > TIME_CODE_MAX) ? TIME_CODE_MAX : timeSel;
    assign target = 32'(BASE_CYCLES) << timeClamp;
    // a shorter setting could leave the count past its end and hang it
    assign codeChange = (timeClamp != timeHeld);

    // code of the period in progress
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timeHeld <= 3'h0;
        end else begin
            timeHeld <= timeClamp;
        end
    end

    // counter restarts whenever the run request drops or the code changes
    always_ff @(posedge sys_clk) begin
        if (reset || !run || codeChange) begin
            count <= 32'h0;
            done <= 1'b0;
        end else if (count == target - 32'h1) begin
            count <= 32'h0;
            done <= 1'b1;
        end else begin
            count <= count + 32'h1;
            done <= 1'b0;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_period;
        done |-> $past(count) == $past(target) - 32'h1;
    endproperty
    a_period: assert property (p_period)
        else $error("integration period length wrong");
endmodule : rgs_meas_timer

// [rtl/rgs_top.sv]
`timescale 1ns/1ps
// Summary of operation
// - configuration word lives at command code 0x00.
// - results at codes 0x08..0x0b: red, green, blue, white.
// - every register is 16 bits; writes and reads move whole words.
// - bus runs from 100 kHz up to 400 kHz.
// - device answers only target address 0x10.
// - config low byte: bits 7,3 zero, 6..4 time, 2 trigger, 1 force, 0 off.
// - time codes 0..5 give 40 to 1280 ms, doubling each step.
// - power-down bit 0 enables sensor when 0, disables when 1.
// - force bit 0 measures continuously; 1 measures only when requested.
// - in force mode a written trigger 1 runs exactly one cycle.
// - config high byte reserved, reads zero.
// - codes 0x01..0x07 reserved, read zero, no function.
// - result low byte carries bits 7..0, high byte bits 15..8.
// - config read/write, results read-only, all over the bus.
// - results hold last values until a new measurement completes.
module rgs_top #(
    parameter int unsigned BASE_CYCLES = rgs_pkg::TIME_BASE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [15:0] redSample,
    input wire logic [15:0] greenSample,
    input wire logic [15:0] blueSample,
    input wire logic [15:0] whiteSample,
    output logic sensorEnable,
    output logic measureBusy,
    output logic resultStrobe
);
    import rgs_pkg::*;

    logic sclS;
    logic sdaS;
    logic sclPrev;
    logic sdaPrev;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    rgs_state_t state;
    logic [3:0] bitCnt;
    logic ackPhase;
    logic byteHigh;
    logic [7:0] rxShift;
    logic [7:0] txShift;
    logic [7:0] cmdCode;
    logic [7:0] wrLow;
    logic addrMatch;
    logic byteDone;
    logic ackDone;
    logic wrCommit;
    logic cfgWrite;
    logic [15:0] wrWord;
    logic [15:0] readWord;
    logic [7:0] readByte;
    logic [15:0] cfgReg;
    logic forceBusy;
    logic kick;
    logic timerRun;
    logic measDone;
    logic [15:0] chanSample [NUM_CHANNELS];
    logic [15:0] chanResult [NUM_CHANNELS];

    // the sampling needs several clocks inside the shortest bus high phase
    if (SCL_HIGH_MIN_CYCLES < 4) begin : g_bus_too_fast
        $error("rgs_top: system clock too slow for 400 kHz bus");
    end

    // both bus lines cross into sys_clk through two flops
    rgs_pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .pinIn({sclIn, sdaIn}),
        .pinSync({sclS, sdaS})
    );

    // previous synced levels for edge and condition detection
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= sclS;
            sdaPrev <= sdaS;
        end
    end

    // bus events; start also covers the repeated start of a read
    assign sclRise = sclS & ~sclPrev;
    assign sclFall = ~sclS & sclPrev;
    assign startCond = sclS & sclPrev & sdaPrev & ~sdaS;
    assign stopCond = sclS & sclPrev & ~sdaPrev & sdaS;

    // byte and acknowledge boundaries, all at the falling clock
    assign byteDone = sclFall & ~ackPhase & (bitCnt == 4'h8);
    assign ackDone = sclFall & ackPhase;
    assign addrMatch = (rxShift[7:1] == TARGET_ADDR);

    // a word is taken only once both bytes arrived, low byte first
    assign wrWord = {rxShift, wrLow};
    assign wrCommit = (state == ST_WRITE) & byteDone & byteHigh;
    assign cfgWrite = wrCommit & (cmdCode == CMD_CONFIG);

    // read selection; reserved and unmapped codes read as zero
    assign readWord = (cmdCode == CMD_CONFIG) ? cfgReg :
                      (cmdCode == CMD_RED) ? chanResult[0] :
                      (cmdCode == CMD_GREEN) ? chanResult[1] :
                      (cmdCode == CMD_BLUE) ? chanResult[2] :
                      (cmdCode == CMD_WHITE) ? chanResult[3] :
                      16'h0000;
    assign readByte = byteHigh ? readWord[15:8] : readWord[7:0];

    // open-drain data pin: only ever pulled low
    assign sdaOut = 1'b0;

    // target protocol engine; start and stop override any bit in flight
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state <= ST_IDLE;
            bitCnt <= 4'h0;
            ackPhase <= 1'b0;
            byteHigh <= 1'b0;
            rxShift <= 8'h00;
            txShift <= 8'h00;
            cmdCode <= 8'h00;
            wrLow <= 8'h00;
            sdaOe <= 1'b0;
        end else if (startCond) begin
            state <= ST_ADDR;
            bitCnt <= 4'h0;
            ackPhase <= 1'b0;
            byteHigh <= 1'b0;
            sdaOe <= 1'b0;
        end else if (stopCond) begin
            state <= ST_IDLE;
            ackPhase <= 1'b0;
            sdaOe <= 1'b0;
        end else if (sclRise) begin
            if (!ackPhase) begin
                rxShift <= {rxShift[6:0], sdaS};
                bitCnt <= (bitCnt == 4'h8) ? bitCnt : bitCnt + 4'h1;
            end else if (state == ST_READ && sdaS) begin
                state <= ST_SKIP; // host nack ends the read word
            end
        end else if (byteDone) begin
            ackPhase <= 1'b1;
            unique case (state)
                ST_ADDR: sdaOe <= addrMatch;
                ST_CMD: begin
                    cmdCode <= rxShift;
                    sdaOe <= 1'b1;
                end
                ST_WRITE: begin
                    // writes to read-only or reserved codes are acked and dropped
                    if (!byteHigh) begin
                        wrLow <= rxShift;
                    end
                    byteHigh <= ~byteHigh;
                    sdaOe <= 1'b1;
                end
                ST_READ: sdaOe <= 1'b0; // release for host ack
                ST_IDLE, ST_SKIP: sdaOe <= 1'b0;
            endcase
        end else if (ackDone) begin
            ackPhase <= 1'b0;
            bitCnt <= 4'h0;
            sdaOe <= 1'b0;
            unique case (state)
                ST_ADDR: begin
                    if (!addrMatch) begin
                        state <= ST_SKIP;
                    end else if (rxShift[0]) begin
                        state <= ST_READ;
                        txShift <= readByte;
                        sdaOe <= ~readByte[7];
                        byteHigh <= ~byteHigh;
                    end else begin
                        state <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    state <= ST_WRITE;
                    byteHigh <= 1'b0;
                end
                ST_READ: begin
                    // host acked: send the other byte of the word
                    txShift <= readByte;
                    sdaOe <= ~readByte[7];
                    byteHigh <= ~byteHigh;
                end
                ST_WRITE, ST_IDLE, ST_SKIP: state <= state;
            endcase
        end else if (sclFall && state == ST_READ && bitCnt != 4'h0) begin
            // next data bit goes out while the clock is low
            txShift <= {txShift[6:0], 1'b0};
            sdaOe <= ~txShift[6];
        end
    end

    // configuration word; fixed-zero bits are masked at every write
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cfgReg <= CFG_RESET;
        end else if (cfgWrite) begin
            cfgReg <= wrWord & CFG_WRITE_MASK;
        end else if (measDone && forceBusy) begin
            cfgReg[CFG_KICK_BIT] <= 1'b0; // trigger reads back as zero once its period ends
        end
    end

    // a force-mode request; a write carrying the trigger wins over its clear
    assign kick = cfgWrite & wrWord[CFG_KICK_BIT] & wrWord[CFG_FORCE_BIT];

    // one-shot request stays until its single period ends, power-down is set or force mode is left
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            forceBusy <= 1'b0;
        end else if (kick) begin
            forceBusy <= ~wrWord[CFG_POWER_DOWN_BIT];
        end else if (measDone || cfgReg[CFG_POWER_DOWN_BIT] || !cfgReg[CFG_FORCE_BIT]) begin
            forceBusy <= 1'b0;
        end
    end

    // shutdown stops all integration; auto mode runs back to back
    assign timerRun = ~cfgReg[CFG_POWER_DOWN_BIT] & (~cfgReg[CFG_FORCE_BIT] | forceBusy);
    assign sensorEnable = ~cfgReg[CFG_POWER_DOWN_BIT];
    assign measureBusy = timerRun;
    assign resultStrobe = measDone;

    rgs_meas_timer #(
        .BASE_CYCLES(BASE_CYCLES)
    ) u_meas_timer (
        .sys_clk(sys_clk),
        .reset(reset),
        .run(timerRun),
        .timeSel(cfgReg[CFG_TIME_MSB:CFG_TIME_LSB]),
        .done(measDone)
    );

    // channel order in the array matches the result command codes
    assign chanSample[0] = redSample;
    assign chanSample[1] = greenSample;
    assign chanSample[2] = blueSample;
    assign chanSample[3] = whiteSample;

    // results latch together and only at the end of a period
    for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                chanResult[ch] <= 16'h0000;
            end else if (measDone) begin
                chanResult[ch] <= chanSample[ch];
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_cfg_fixed_zero;
        cfgReg[15:8] == 8'h00 && !cfgReg[7] && !cfgReg[3];
    endproperty
    a_cfg_fixed_zero: assert property (p_cfg_fixed_zero)
        else $error("fixed-zero config bits set");

    property p_addr_ack;
        byteDone && state == ST_ADDR && addrMatch |=> sdaOe && ackPhase;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("own address not acknowledged");

    property p_addr_ignore;
        (state == ST_SKIP) || (byteDone && state == ST_ADDR && !addrMatch) |=> !sdaOe;
    endproperty
    a_addr_ignore: assert property (p_addr_ignore)
        else $error("foreign address drove data line");

    property p_shutdown;
        cfgReg[CFG_POWER_DOWN_BIT] |-> !sensorEnable && !timerRun ##1 !measDone;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("sensor active while shut down");

    property p_force_idle;
        cfgReg[CFG_FORCE_BIT] && !forceBusy && !cfgWrite |=> !timerRun;
    endproperty
    a_force_idle: assert property (p_force_idle)
        else $error("force mode measuring without request");

    property p_kick_runs;
        kick && !wrWord[CFG_POWER_DOWN_BIT] |=> forceBusy && timerRun;
    endproperty
    a_kick_runs: assert property (p_kick_runs)
        else $error("trigger did not start a cycle");

    property p_one_shot;
        measDone && cfgReg[CFG_FORCE_BIT] && !kick |=> !forceBusy;
    endproperty
    a_one_shot: assert property (p_one_shot)
        else $error("force mode ran more than one cycle");

    property p_result_hold;
        !measDone |=> $stable(chanResult[0]) && $stable(chanResult[3]);
    endproperty
    a_result_hold: assert property (p_result_hold)
        else $error("result changed without measurement");

    property p_result_latch;
        measDone |=> chanResult[1] == $past(greenSample) && chanResult[2] == $past(blueSample);
    endproperty
    a_result_latch: assert property (p_result_latch)
        else $error("results not latched together");

    property p_cfg_write;
        cfgWrite |=> cfgReg[6:4] == $past(wrWord[6:4]) && cfgReg[1:0] == $past(wrWord[1:0]);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("config write not stored");

    property p_read_only;
        wrCommit && cmdCode != CMD_CONFIG && !measDone |=> $stable(cfgReg) && $stable(chanResult[0]);
    endproperty
    a_read_only: assert property (p_read_only)
        else $error("write to read-only code changed state");

    c_addr_read: cover property (ackDone && state == ST_ADDR && addrMatch && rxShift[0]);
    c_cfg_write: cover property (cfgWrite);
    c_meas_done: cover property (measDone);
    c_host_nack: cover property (sclRise && ackPhase && state == ST_READ && sdaS);
endmodule : rgs_top

// [test/rgs_host_model.sv]
`timescale 1ns/1ps
// bus controller: open-drain lines with pull-ups, clock still between frames
module rgs_host_model (
    input wire logic sdaOe,
    output logic sclIn,
    output logic sdaIn
);
    localparam int Q = 40;
    logic sclDrv = 1'b1;
    logic sdaDrv = 1'b1;

    // a released line floats high, so a silent device reads as nack
    assign sclIn = sclDrv;
    assign sdaIn = sdaDrv & (sdaOe !== 1'b1);

    // data changes only with the clock low
    task bit_out(input logic b);
        sclDrv = 1'b0;
        #Q sdaDrv = b;
        #Q sclDrv = 1'b1;
        #(2*Q);
    endtask : bit_out

    // sample late in the high phase, long after the device has settled
    task bit_in(output logic b);
        sclDrv = 1'b0;
        sdaDrv = 1'b1;
        #(2*Q) sclDrv = 1'b1;
        #(2*Q-5) b = sdaIn;
        #5;
    endtask : bit_in

    // start and repeated start alike: data falls with the clock high
    task cond_start;
        sclDrv = 1'b0;
        #Q sdaDrv = 1'b1;
        #Q sclDrv = 1'b1;
        #(2*Q) sdaDrv = 1'b0;
        #(2*Q);
    endtask : cond_start

    task cond_stop;
        sclDrv = 1'b0;
        #Q sdaDrv = 1'b0;
        #Q sclDrv = 1'b1;
        #(2*Q) sdaDrv = 1'b1;
        #(4*Q);
    endtask : cond_stop

    // byte out, most significant bit first; ok drops at a nack
    task send(input logic [7:0] b, inout logic ok);
        logic a;
        for (int i = 7; i >= 0; i--) bit_out(b[i]);
        bit_in(a);
        ok = ok & ~a;
    endtask : send

    task recv(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) bit_in(b[i]);
        bit_out(last); // ack first byte, nack the last
    endtask : recv

    // whole word only, low byte first
    task write_word(input logic [6:0] adr, input logic [7:0] cmd, input logic [15:0] d,
                    output logic ok);
        ok = 1'b1;
        cond_start();
        send({adr, 1'b0}, ok);
        send(cmd, ok);
        send(d[7:0], ok);
        send(d[15:8], ok);
        cond_stop();
    endtask : write_word

    // read word with repeated start and no stop after the code
    task read_word(input logic [6:0] adr, input logic [7:0] cmd, output logic [15:0] d,
                   output logic ok);
        ok = 1'b1;
        cond_start();
        send({adr, 1'b0}, ok);
        send(cmd, ok);
        cond_start();
        send({adr, 1'b1}, ok);
        recv(1'b0, d[7:0]);
        recv(1'b1, d[15:8]);
        cond_stop();
    endtask : read_word
endmodule : rgs_host_model

// [test/rgs_top_test.sv]
`timescale 1ns/1ps
// self-checking bench: host model at the bus, reference copy of the results
module rgs_top_test;
    import rgs_pkg::*;
    localparam int unsigned BASE = 50;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic sclIn, sdaIn, sdaOut, sdaOe, sensorEnable, measureBusy, resultStrobe;
    logic [15:0] sample [4] = '{default: 16'h0000};
    logic [15:0] modelRes [4] = '{default: 16'h0000};
    int miscompares = 0;
    int checks = 0;
    int seed = 55555;
    int strobes = 0;

    rgs_top #(.BASE_CYCLES(BASE)) i_rgs_top (
        .sys_clk(sys_clk), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .redSample(sample[0]),
        .greenSample(sample[1]), .blueSample(sample[2]), .whiteSample(sample[3]),
        .sensorEnable(sensorEnable), .measureBusy(measureBusy),
        .resultStrobe(resultStrobe));
    rgs_host_model i_rgs_host_model (.sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));

    always #10 sys_clk = ~sys_clk;

    // fresh counts every cycle; the reference copies all four at a strobe
    always @(posedge sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            sample[i] <= 16'($random(seed));
            if (reset) modelRes[i] = 16'h0000;
            else if (resultStrobe === 1'b1) modelRes[i] = sample[i];
        end
        if (resultStrobe === 1'b1) strobes++;
    end

    task check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task stop_test;
        if (miscompares == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task wr(input logic [7:0] cmd, input logic [15:0] d);
        logic ok;
        i_rgs_host_model.write_word(TARGET_ADDR, cmd, d, ok);
        check("write ack", 16'h1, {15'h0, ok});
    endtask : wr

    task rd(input logic [7:0] cmd, input logic [15:0] exp);
        logic ok;
        logic [15:0] d;
        i_rgs_host_model.read_word(TARGET_ADDR, cmd, d, ok);
        check("read ack", 16'h1, {15'h0, ok});
        check($sformatf("reg %h", cmd), exp, d);
    endtask : rd

    task results;
        for (int i = 0; i < 4; i++) rd(CMD_RED + 8'(i), modelRes[i]);
    endtask : results

    // strobes counted from a snapshot over a fixed window
    task count_from(input int s0, input string nm, input int exp);
        repeat (300) @(negedge sys_clk);
        check(nm, 16'(exp), 16'(strobes - s0));
    endtask : count_from

    // gap between two auto periods; bounded, an overrun shows as a wrong gap
    task period(input int p);
        int s0;
        int c;
        s0 = strobes;
        c = 0;
        while (strobes == s0 && c < 4*p) begin
            @(negedge sys_clk);
            c++;
        end
        s0 = strobes;
        c = 0;
        while (strobes == s0 && c < 4*p) begin
            @(negedge sys_clk);
            c++;
        end
        check("period", 16'(p), (c >= p && c <= p + 2) ? 16'(p) : 16'(c));
    endtask : period

    // a hang anywhere ends the run as a failure
    initial begin
        repeat (100000) @(posedge sys_clk);
        miscompares++;
        stop_test();
    end

    initial begin
        logic ok;
        int s0;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        check("sensorEnable", 16'h1, {15'h0, sensorEnable});
        check("measureBusy", 16'h1, {15'h0, measureBusy});
        check("sdaOut", 16'h0, {15'h0, sdaOut});
        rd(CMD_CONFIG, CFG_RESET);
        for (int c = 1; c <= 7; c++) rd(8'(c), 16'h0000);
        rd(8'h0c, 16'h0000);
        // a foreign address gets no ack and changes nothing
        i_rgs_host_model.write_word(TARGET_ADDR + 7'h1, CMD_CONFIG, 16'h0001, ok);
        check("foreign ack", 16'h0, {15'h0, ok});
        rd(CMD_CONFIG, CFG_RESET);
        // every integration code, auto mode back to back; codes 6 and 7 run as 5
        for (int k = 0; k <= 7; k++) begin
            wr(CMD_CONFIG, 16'(k << CFG_TIME_LSB));
            rd(CMD_CONFIG, 16'(k << CFG_TIME_LSB));
            period(BASE << ((k > 5) ? 5 : k));
        end
        // fixed-zero bits and reserved high byte drop; power-down freezes results
        wr(CMD_CONFIG, 16'hff7b);
        rd(CMD_CONFIG, 16'h0073);
        check("sensorEnable", 16'h0, {15'h0, sensorEnable});
        check("measureBusy", 16'h0, {15'h0, measureBusy});
        count_from(strobes, "strobes off", 0);
        results();
        wr(CMD_RED, ~modelRes[0]);
        results();
        // force mode idles until one trigger, which gives exactly one period
        wr(CMD_CONFIG, 16'h0002);
        check("sensorEnable", 16'h1, {15'h0, sensorEnable});
        count_from(strobes, "strobes forced", 0);
        s0 = strobes;
        wr(CMD_CONFIG, 16'h0006);
        count_from(s0, "strobes kicked", 1);
        rd(CMD_CONFIG, 16'h0002);
        results();
        stop_test();
    end
endmodule : rgs_top_test
